// file: rtl/mdp_param_set.sv
// Chosen here: strobed register access and the address map.
module mdp_param_set
  import mdp_pkg::*;
(
  input  wire logic               clk,             // system clock
  input  wire logic               nrst,            // async reset, low
  input  wire logic [7:0]         busAddr,         // register word address
  input  wire logic [15:0]        busWdata,        // write data
  input  wire logic               busWr,           // write strobe
  input  wire logic               busRd,           // read strobe
  input  wire logic               busFromSetter,   // access from setter
  output logic      [15:0]        busRdata,        // read data
  input  wire logic [13:0]        anaMv,           // analog input, mV
  input  wire logic [11:0]        digSpeed,        // digital speed
  input  wire logic [7:0]         digTorque,       // digital torque
  input  wire logic               inchingActive,   // jog running
  input  wire logic [7:0]         loadPct,         // load torque, %
  input  wire logic signed [12:0] monSpeed,        // measured speed
  input  wire logic               alarmActive,     // any alarm present
  input  wire logic               alarmOne,        // alarm output one
  input  wire logic               alarmTwo,        // alarm output two
  input  wire logic               moving,          // motor moving
  input  wire logic               torqueLimiting,  // limiting torque
  input  wire logic               speedAttained,   // speed reached
  input  wire logic               internalBusy,    // driver busy
  input  wire logic               mainPower,       // main power on
  input  wire logic               dirReverse,      // turning reverse
  input  wire logic               motorStopped,    // shaft at rest
  input  wire logic               auxPowerPin,     // 24 V present, pin
  input  wire logic               thermAssigned,   // a pin has thermal
  output logic                    forwardRun,      // forward run
  output logic                    reverseRun,      // reverse run
  output logic                    stopModeSel,     // stop mode select
  output logic                    brakeRelease,    // brake release
  output logic                    panelLockRelease,// panel lock
  output logic      [15:0]        generalBit,      // general bits
  output logic      [3:0]         dataSelectBit,   // op data number
  output logic                    torqueLimitEnable, // limit enable
  output logic      [15:0]        networkOutputBit,  // network outputs
  output logic      [11:0]        speedCmd,        // speed command
  output logic      [7:0]         torqueCmd,       // torque limit
  output logic                    warningOutput,   // overload warning
  output logic signed [12:0]      dispSpeed,       // displayed speed
  output logic                    dispNeg,         // show minus sign
  output logic                    editAllowed,     // setter may edit
  output logic      [2:0]         startScreen,     // setter start view
  output logic      [1:0]         analogSel,       // analog source
  output logic                    brakeLock,       // engage brake
  output logic                    regenOverheat,   // overheat alarm
  output logic                    pwmShutoffEn,    // PWM shut-off on
  output logic                    noOpInitAlarm    // no-op at alarm
);

  // ***************************************
  // reset release
  // ***************************************
  logic rstMeta_r;
  logic rstN;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN      <= rstMeta_r;
    end
  end

  // ***************************************
  // register decode
  // ***************************************
  logic [15:0] prm_r     [NPRM];
  logic [15:0] act_r     [NPRM];
  logic [15:0] eff       [NPRM];
  logic [6:0]  selIn_r   [NBIT];
  logic [6:0]  selInA_r  [NBIT];
  logic [6:0]  selOut_r  [NBIT];
  logic [6:0]  selOutA_r [NBIT];
  logic [15:0] netIn_r;

  logic        wrOk;
  logic        prmHit;
  logic        prmLegal;
  logic        selInHit;
  logic        selOutHit;
  logic        cfgHit;
  logic        apply;
  logic        clrAlarm;
  logic [4:0]  idx;
  logic signed [15:0] wS;

  function automatic logic prm_legal(input logic [4:0] i,
                                     input logic [15:0] d);
    logic signed [15:0] s;
    s = $signed(d);
    prm_legal = (s >= PRM_MIN[i]) && (s <= PRM_MAX[i]) &&
                !(i == I_JOG_SPD && d != 16'h0000 && d < JOG_MIN);
  endfunction

  // setter writes are dropped while editing is locked
  assign wrOk      = busWr & (~busFromSetter | eff[I_EDIT_MD][0]);
  assign idx       = busAddr[4:0];
  assign wS        = $signed(busWdata);
  assign prmHit    = busAddr < 8'(NPRM);
  assign prmLegal  = prm_legal(idx, busWdata);
  assign selInHit  = busAddr[7:4] == A_SEL_IN;
  assign selOutHit = busAddr[7:4] == A_SEL_OUT;
  assign cfgHit    = wrOk & (busAddr == A_CONFIG);
  assign apply     = cfgHit & busWdata[CFG_APPLY];
  assign clrAlarm  = cfgHit & busWdata[CFG_CLR];

  // ***************************************
  // parameter store, pending and active
  // ***************************************
  genvar g;
  generate
    for (g = 0; g < NPRM; g++) begin : gPrm
      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          prm_r[g] <= PRM_RST[g];
          act_r[g] <= PRM_RST[g];
        end else begin
          if (wrOk && prmHit && prmLegal && idx == 5'(g)) begin
            prm_r[g] <= busWdata;
          end
          if (apply) begin
            act_r[g] <= prm_r[g];
          end
        end
      end
      assign eff[g] = PRM_CLS_C[g] ? act_r[g] : prm_r[g];
    end

    for (g = 0; g < NBIT; g++) begin : gSel
      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          selIn_r[g]   <= SEL_IN_RST[g];
          selInA_r[g]  <= SEL_IN_RST[g];
          selOut_r[g]  <= SEL_OUT_RST[g];
          selOutA_r[g] <= SEL_OUT_RST[g];
        end else begin
          if (wrOk && selInHit && busAddr[3:0] == 4'(g) &&
              busWdata[15:7] == 9'h000 && IN_MASK[busWdata[6:0]]) begin
            selIn_r[g] <= busWdata[6:0];
          end
          if (wrOk && selOutHit && busAddr[3:0] == 4'(g) &&
              busWdata[15:7] == 9'h000 && OUT_MASK[busWdata[6:0]]) begin
            selOut_r[g] <= busWdata[6:0];
          end
          if (apply) begin
            selInA_r[g]  <= selIn_r[g];
            selOutA_r[g] <= selOut_r[g];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      netIn_r <= 16'h0000;
    end else if (wrOk && busAddr == A_NETWORK_INPUT_BIT) begin
      netIn_r <= busWdata;
    end
  end

  // ***************************************
  // network input function decode
  // ***************************************
  logic [FNW-1:0] fnAcc [NBIT+1];
  logic [FNW-1:0] fnIn;
  assign fnAcc[0] = '0;
  generate
    for (g = 0; g < NBIT; g++) begin : gFn
      assign fnAcc[g+1] = fnAcc[g] |
        (netIn_r[g] ? (FNW'(1) << selInA_r[g]) : '0);
    end
  endgenerate
  // code 0 is no function, so it never echoes as a live bit
  assign fnIn = fnAcc[NBIT] & IN_MASK & ~FNW'(1);

  // ***************************************
  // network output source vector
  // ***************************************
  logic [FNW-1:0] statVec;
  logic [FNW-1:0] outVec;
  logic [15:0]    netOutNxt;
  logic           ovlWarn;
  assign statVec = (FNW'(alarmOne)       << FN_ALM1) |
                   (FNW'(ovlWarn)        << FN_WNG)  |
                   (FNW'(moving)         << FN_MOVE) |
                   (FNW'(torqueLimiting) << FN_TLC)  |
                   (FNW'(speedAttained)  << FN_VA)   |
                   (FNW'(internalBusy)   << FN_BSY)  |
                   (FNW'(alarmTwo)       << FN_ALM2) |
                   (FNW'(mainPower)      << FN_MPS)  |
                   (FNW'(dirReverse)     << FN_DIR);
  assign outVec = fnIn | statVec;
  generate
    for (g = 0; g < NBIT; g++) begin : gOut
      assign netOutNxt[g] = outVec[selOutA_r[g]];
    end
  endgenerate

  // ***************************************
  // analog scaling
  // ***************************************
  logic [25:0]        spdProd;
  logic [25:0]        spdQ;
  logic signed [27:0] spdSum;
  logic [11:0]        spdAna;
  logic [21:0]        trqProd;
  logic [21:0]        trqQ;
  logic signed [23:0] trqSum;
  logic [7:0]         trqAna;
  logic [15:0]        spdMax;
  logic [15:0]        trqMax;

  assign spdProd = eff[I_SPD_GAIN][11:0] * anaMv;
  assign spdQ    = spdProd / MV_PER_V;
  assign spdSum  = $signed({2'b00, spdQ}) +
                   $signed({{12{eff[I_SPD_OFS][15]}},
                            eff[I_SPD_OFS]});
  assign spdMax  = eff[I_SPD_MAX];
  assign spdAna  = spdSum < 0 ? 12'h000 :
                   (spdSum > $signed({12'h000, spdMax})) ?
                   spdMax[11:0] : spdSum[11:0];

  assign trqProd = eff[I_TRQ_GAIN][7:0] * anaMv;
  assign trqQ    = trqProd / MV_PER_V[21:0];
  assign trqSum  = $signed({2'b00, trqQ}) +
                   $signed({{8{eff[I_TRQ_OFS][15]}},
                            eff[I_TRQ_OFS]});
  assign trqMax  = eff[I_TRQ_MAX];
  assign trqAna  = trqSum < 0 ? 8'h00 :
                   (trqSum > $signed({8'h00, trqMax})) ?
                   trqMax[7:0] : trqSum[7:0];

  // ***************************************
  // command selection
  // ***************************************
  logic [1:0]  anaSel;
  logic        spdFromAna;
  logic        trqFromAna;
  logic [11:0] spdNxt;
  logic [7:0]  trqNxt;
  assign anaSel     = eff[I_ANA_SEL][1:0];
  assign spdFromAna = (anaSel == 2'h1) &&
                      (fnIn[FN_DSEL0 +: 4] == 4'h0);
  assign trqFromAna = anaSel == 2'h2;
  assign spdNxt = inchingActive ? eff[I_JOG_SPD][11:0] :
                  spdFromAna    ? spdAna : digSpeed;
  assign trqNxt = inchingActive ? eff[I_JOG_TRQ][7:0] :
                  trqFromAna    ? trqAna : digTorque;

  // ***************************************
  // warning and display
  // ***************************************
  logic signed [12:0] spdAbs;
  logic               monNeg;
  logic               signedMode;
  assign ovlWarn = eff[I_OVL_EN][0] &&
                   ({8'h00, loadPct} >= eff[I_OVL_LVL]);
  assign monNeg     = monSpeed < 0;
  assign spdAbs     = monNeg ? -monSpeed : monSpeed;
  assign signedMode = ~eff[I_DISP_MD][0];

  // ***************************************
  // brake at alarm
  // ***************************************
  mdp_brake_t bk_r;
  mdp_brake_t bk_nxt;
  always_comb begin
    bk_nxt = bk_r;
    unique case (bk_r)
      BK_IDLE: begin
        if (alarmActive) begin
          bk_nxt = act_r[I_BRK_ALM][0] ? BK_LOCK : BK_COAST;
        end
      end
      BK_COAST: begin
        if (!alarmActive) begin
          bk_nxt = BK_IDLE;
        end else if (motorStopped) begin
          bk_nxt = BK_LOCK;
        end
      end
      BK_LOCK: begin
        if (!alarmActive) begin
          bk_nxt = BK_IDLE;
        end
      end
      default: bk_nxt = BK_IDLE;
    endcase
  end

  // ***************************************
  // initial thermal detection
  // ***************************************
  logic auxMeta_r;
  logic auxSync_r;
  logic auxDly_r;
  logic therm_r;
  logic therm_nxt;
  logic thermSet;
  assign thermSet  = auxSync_r & ~auxDly_r &
                     act_r[I_INIT_TH][0] & ~thermAssigned;
  assign therm_nxt = thermSet | (therm_r & ~clrAlarm);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      auxMeta_r <= 1'b0;
      auxSync_r <= 1'b0;
      auxDly_r  <= 1'b0;
      therm_r   <= 1'b0;
      bk_r      <= BK_IDLE;
    end else begin
      auxMeta_r <= auxPowerPin;
      auxSync_r <= auxMeta_r;
      auxDly_r  <= auxSync_r;
      therm_r   <= therm_nxt;
      bk_r      <= bk_nxt;
    end
  end

  // ***************************************
  // read mux
  // ***************************************
  logic [15:0] status;
  logic [15:0] rdMux;
  assign status = {12'h000, ~act_r[I_RUN_MD][0], therm_r,
                   ovlWarn, bk_r == BK_LOCK};
  always_comb begin
    rdMux = 16'h0000;
    if (prmHit) begin
      rdMux = prm_r[idx];
    end else if (selInHit) begin
      rdMux = {9'h000, selIn_r[busAddr[3:0]]};
    end else if (selOutHit) begin
      rdMux = {9'h000, selOut_r[busAddr[3:0]]};
    end else begin
      unique case (busAddr)
        A_NETWORK_INPUT_BIT:  rdMux = netIn_r;
        A_NETWORK_OUTPUT_BIT: rdMux = networkOutputBit;
        A_STATUS:  rdMux = status;
        A_SPD_CMD: rdMux = {4'h0, speedCmd};
        A_TRQ_CMD: rdMux = {8'h00, torqueCmd};
        A_DISP:    rdMux = {{3{dispSpeed[12]}}, dispSpeed};
        default:   rdMux = 16'h0000;
      endcase
    end
  end

  // ***************************************
  // registered outputs
  // ***************************************
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busRdata          <= 16'h0000;
      forwardRun        <= 1'b0;
      reverseRun        <= 1'b0;
      stopModeSel       <= 1'b0;
      brakeRelease      <= 1'b0;
      panelLockRelease  <= 1'b0;
      generalBit        <= 16'h0000;
      dataSelectBit     <= 4'h0;
      torqueLimitEnable <= 1'b0;
      networkOutputBit  <= 16'h0000;
      speedCmd          <= 12'h000;
      torqueCmd         <= 8'h00;
      warningOutput     <= 1'b0;
      dispSpeed         <= 13'h0000;
      dispNeg           <= 1'b0;
      editAllowed       <= 1'b0;
      startScreen       <= 3'h0;
      analogSel         <= 2'h0;
      brakeLock         <= 1'b0;
      regenOverheat     <= 1'b0;
      pwmShutoffEn      <= 1'b0;
      noOpInitAlarm     <= 1'b0;
    end else begin
      busRdata          <= busRd ? rdMux : 16'h0000;
      forwardRun        <= fnIn[FN_FWD];
      reverseRun        <= fnIn[FN_REV];
      stopModeSel       <= fnIn[FN_STOP];
      brakeRelease      <= fnIn[FN_BRK];
      panelLockRelease  <= fnIn[FN_PNL];
      generalBit        <= fnIn[FN_GEN0 +: 16];
      dataSelectBit     <= fnIn[FN_DSEL0 +: 4];
      torqueLimitEnable <= fnIn[FN_TLE];
      networkOutputBit  <= netOutNxt;
      speedCmd          <= spdNxt;
      torqueCmd         <= trqNxt;
      warningOutput     <= ovlWarn;
      dispSpeed         <= signedMode ? monSpeed : spdAbs;
      dispNeg           <= signedMode & monNeg;
      editAllowed       <= eff[I_EDIT_MD][0];
      startScreen       <= act_r[I_INIT_SCR][2:0];
      analogSel         <= anaSel;
      brakeLock         <= bk_nxt == BK_LOCK;
      regenOverheat     <= therm_nxt;
      pwmShutoffEn      <= ~act_r[I_RUN_MD][0];
      noOpInitAlarm     <= act_r[I_NOOP_ALM][0];
    end
  end

endmodule

// file: rtl/mdp_pkg.sv
package mdp_pkg;
  localparam int NBIT = 16;
  localparam int NPRM = 18;
  localparam int FNW  = 128;

  // ***************************************
  // parameter word indices (word addresses)
  // ***************************************
  localparam logic [4:0] I_SPD_GAIN = 5'h00;
  localparam logic [4:0] I_SPD_OFS  = 5'h01;
  localparam logic [4:0] I_TRQ_GAIN = 5'h02;
  localparam logic [4:0] I_TRQ_OFS  = 5'h03;
  localparam logic [4:0] I_SPD_MAX  = 5'h04;
  localparam logic [4:0] I_TRQ_MAX  = 5'h05;
  localparam logic [4:0] I_OVL_LVL  = 5'h06;
  localparam logic [4:0] I_OVL_EN   = 5'h07;
  localparam logic [4:0] I_JOG_SPD  = 5'h08;
  localparam logic [4:0] I_JOG_TRQ  = 5'h09;
  localparam logic [4:0] I_DISP_MD  = 5'h0A;
  localparam logic [4:0] I_EDIT_MD  = 5'h0B;
  localparam logic [4:0] I_INIT_SCR = 5'h0C;
  localparam logic [4:0] I_ANA_SEL  = 5'h0D;
  localparam logic [4:0] I_NOOP_ALM = 5'h0E;
  localparam logic [4:0] I_BRK_ALM  = 5'h0F;
  localparam logic [4:0] I_INIT_TH  = 5'h10;
  localparam logic [4:0] I_RUN_MD   = 5'h11;

  localparam logic [7:0] A_CONFIG  = 8'h12;
  localparam logic [7:0] A_NETWORK_INPUT_BIT  = 8'h13;
  localparam logic [7:0] A_NETWORK_OUTPUT_BIT = 8'h14;
  localparam logic [7:0] A_STATUS  = 8'h15;
  localparam logic [7:0] A_SPD_CMD = 8'h16;
  localparam logic [7:0] A_TRQ_CMD = 8'h17;
  localparam logic [7:0] A_DISP    = 8'h18;
  localparam logic [3:0] A_SEL_IN  = 4'h2;
  localparam logic [3:0] A_SEL_OUT = 4'h3;

  localparam int CFG_APPLY = 0;
  localparam int CFG_CLR   = 1;
  localparam int ST_BRAKE  = 0;
  localparam int ST_WARN   = 1;
  localparam int ST_THERM  = 2;
  localparam int ST_PWMOFF = 3;

  // ***************************************
  // reset values and legal ranges
  // ***************************************
  localparam logic [15:0] PRM_RST [NPRM] = '{
    16'h0320, 16'h0000, 16'h0028, 16'h0000, 16'h0FA0, 16'h00C8,
    16'h0064, 16'h0000, 16'h012C, 16'h00C8, 16'h0000, 16'h0001,
    16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0001};
  localparam logic signed [15:0] PRM_MIN [NPRM] = '{
    16'h0000, 16'hF830, 16'h0000, 16'hFFCE, 16'h0000, 16'h0000,
    16'h0032, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic signed [15:0] PRM_MAX [NPRM] = '{
    16'h0FA0, 16'h07D0, 16'h00C8, 16'h0032, 16'h0FA0, 16'h00C8,
    16'h0064, 16'h0001, 16'h03E8, 16'h00C8, 16'h0001, 16'h0001,
    16'h0004, 16'h0002, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
  localparam logic [15:0] JOG_MIN = 16'h0050;
  localparam logic [NPRM-1:0] PRM_CLS_C = 18'h3F000;
  localparam logic [25:0] MV_PER_V = 26'h00003E8;

  // ***************************************
  // network function codes
  // ***************************************
  localparam logic [6:0] FN_FWD   = 7'h01;
  localparam logic [6:0] FN_REV   = 7'h02;
  localparam logic [6:0] FN_STOP  = 7'h13;
  localparam logic [6:0] FN_BRK   = 7'h14;
  localparam logic [6:0] FN_PNL   = 7'h1B;
  localparam logic [6:0] FN_GEN0  = 7'h20;
  localparam logic [6:0] FN_DSEL0 = 7'h30;
  localparam logic [6:0] FN_TLE   = 7'h36;
  localparam logic [6:0] FN_ALM1  = 7'h41;
  localparam logic [6:0] FN_WNG   = 7'h42;
  localparam logic [6:0] FN_MOVE  = 7'h44;
  localparam logic [6:0] FN_TLC   = 7'h47;
  localparam logic [6:0] FN_VA    = 7'h4D;
  localparam logic [6:0] FN_BSY   = 7'h50;
  localparam logic [6:0] FN_ALM2  = 7'h51;
  localparam logic [6:0] FN_MPS   = 7'h52;
  localparam logic [6:0] FN_DIR   = 7'h54;
  localparam logic [FNW-1:0] IN_MASK =
    128'h0000_0000_0000_0000_004F_FFFF_0818_0007;
  localparam logic [FNW-1:0] OUT_MASK =
    128'h0000_0000_0017_2096_004F_FFFF_0818_0007;
  localparam logic [6:0] SEL_IN_RST [NBIT] = '{
    7'h30, 7'h31, 7'h32, 7'h01, 7'h02, 7'h13, 7'h14, 7'h00,
    7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  localparam logic [6:0] SEL_OUT_RST [NBIT] = '{
    7'h30, 7'h31, 7'h32, 7'h01, 7'h02, 7'h13, 7'h42, 7'h41,
    7'h50, 7'h00, 7'h00, 7'h00, 7'h51, 7'h44, 7'h4D, 7'h47};

  typedef enum logic [1:0] {
    BK_IDLE  = 2'b00,
    BK_COAST = 2'b01,
    BK_LOCK  = 2'b11
  } mdp_brake_t;
endpackage

// file: tb/mdp_host.sv
module mdp_host (
  input  wire logic        clk,           // clock
  output logic      [7:0]  busAddr,       // address
  output logic      [15:0] busWdata,      // write data
  output logic             busWr,         // write strobe
  output logic             busRd,         // read strobe
  output logic             busFromSetter, // setter flag
  input  wire logic [15:0] busRdata       // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {busAddr, busWdata, busWr, busRd, busFromSetter} = '0;
  // run mode word is never written with 0 by this host
  task wr(input logic [7:0] a, input logic [15:0] d, input logic s);
    @(posedge clk);
    {busAddr, busWdata, busWr, busFromSetter} <= {a, d, 1'b1, s};
    @(posedge clk);
    {busWdata, busWr, busFromSetter} <= {~d, 1'b0, 1'b0};
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    {busAddr, busRd} <= {a, 1'b1};
    @(posedge clk);
    busRd <= 1'b0;
    #1 d = busRdata;
  endtask
endmodule

// file: tb/mdp_param_set_sva.sv
module mdp_param_set_sva (
  input wire logic               clk, nrst, busRd, inchingActive,
  input wire logic               alarmActive, thermAssigned, dispNeg,
  input wire logic               warningOutput, brakeLock, regenOverheat,
  input wire logic        [15:0] busRdata,  // read data
  input wire logic        [11:0] digSpeed,  // digital speed
  input wire logic        [11:0] speedCmd,  // speed out
  input wire logic        [7:0]  loadPct,   // load
  input wire logic        [7:0]  torqueCmd, // torque out
  input wire logic        [1:0]  analogSel, // source
  input wire logic signed [12:0] monSpeed,  // measured
  input wire logic signed [12:0] dispSpeed  // shown
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] upCnt_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) upCnt_r <= 2'h0;
    else if (upCnt_r != 2'h3) upCnt_r <= upCnt_r + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!$past(busRd) |-> busRdata == 16'h0)
    else $error("read data outside read slot");
  a_speed_cap: assert property (speedCmd <= 12'hFA0)
    else $error("speed above cap");
  a_torque_cap: assert property (torqueCmd <= 8'hC8)
    else $error("torque above cap");
  a_warn_level: assert property (warningOutput |->
    $past(loadPct) >= 8'h32)
    else $error("warning below lowest level");
  a_digital_speed: assert property (upCnt_r == 2'h3 &&
    analogSel == 2'h0 && !inchingActive ##1 analogSel == 2'h0
    |-> speedCmd == $past(digSpeed))
    else $error("digital speed not passed");
  a_jog_range: assert property (inchingActive |=> (speedCmd == 12'h0 ||
    speedCmd inside {[12'h050:12'h3E8]}) && torqueCmd <= 8'hC8)
    else $error("jog command out of range");
  a_minus_cause: assert property (dispNeg |-> $past(monSpeed) < 0)
    else $error("minus without reverse");
  a_disp_sign: assert property (dispSpeed < 0 |-> dispNeg)
    else $error("negative shown without minus");
  a_brake_alarm: assert property (brakeLock |-> $past(alarmActive))
    else $error("brake without alarm");
  a_heat_cause: assert property ($rose(regenOverheat) |->
    !$past(thermAssigned))
    else $error("overheat with thermal assigned");
  c_warn: cover property (warningOutput);
  c_brake: cover property (brakeLock);
  c_heat: cover property (regenOverheat);
endmodule
bind mdp_param_set mdp_param_set_sva mdp_param_set_sva_inst (.*);

// file: tb/test_mdp_param_set.sv
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  error_cnt++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module test_mdp_param_set
  import mdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, busWr, busRd, busFromSetter, inchingActive = 0;
  logic alarmActive = 0, alarmOne = 0, alarmTwo = 0, moving = 0;
  logic torqueLimiting = 0, speedAttained = 0, internalBusy = 0;
  logic mainPower = 0, dirReverse = 0, motorStopped = 0, auxPowerPin = 0;
  logic thermAssigned = 0, forwardRun, reverseRun, stopModeSel, dispNeg;
  logic brakeRelease, panelLockRelease, torqueLimitEnable, warningOutput;
  logic editAllowed, brakeLock, regenOverheat, pwmShutoffEn, noOpInitAlarm;
  logic [7:0] busAddr, digTorque = 8'h50, loadPct = 8'h64, torqueCmd;
  logic [15:0] busWdata, busRdata, generalBit, networkOutputBit, rv;
  logic [13:0] anaMv = 14'h1388;
  logic [11:0] digSpeed = 12'h123, speedCmd;
  logic signed [12:0] monSpeed = 13'h1F9C, dispSpeed;
  logic [3:0] dataSelectBit;
  logic [2:0] startScreen;
  logic [1:0] analogSel;
  int error_cnt = 0, check_count = 0;
  always #5 clk = ~clk;
  mdp_param_set mdp_param_set_inst (.*);
  mdp_host mdp_host_inst (.*);
  // ****************
  // scenarios
  // ****************
  task w(input logic [7:0] a, input logic [15:0] d);
    mdp_host_inst.wr(a, d, 1'b0);
  endtask
  task st(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task t_dflt;
    for (int i = 0; i < NPRM; i++) begin
      mdp_host_inst.rd(8'(i), rv);
      `CHK("prm", PRM_RST[i], rv)
    end
    `CHK("edit", 1'b1, editAllowed)
    `CHK("asel", 2'h1, analogSel)
    `CHK("pwm", 1'b0, pwmShutoffEn)
    `CHK("noop", 1'b0, noOpInitAlarm)
    `CHK("scr", 3'h0, startScreen)
    $display("t_dflt done");
  endtask
  task t_ana;
    `CHK("spd", 12'hFA0, speedCmd)
    w(8'h01, 16'hF830); st(3); `CHK("spd", 12'h7D0, speedCmd)
    w(8'h04, 16'h03E8); st(3); `CHK("spd", 12'h3E8, speedCmd)
    w(8'h00, 16'h0000); st(3); `CHK("spd", 12'h000, speedCmd)
    w(8'h0D, 16'h0); st(2); `CHK("asel", 2'h1, analogSel)
    w(8'h12, 16'h1); st(3); `CHK("asel", 2'h0, analogSel)
    `CHK("spd", 12'h123, speedCmd)
    w(8'h0D, 16'h2); w(8'h12, 16'h1); w(8'h02, 16'h14); w(8'h03, 16'hFFCE);
    st(3); `CHK("trq", 8'h32, torqueCmd)
    w(8'h02, 16'hC8); st(3); `CHK("trq", 8'hC8, torqueCmd)
    @(posedge clk) inchingActive <= 1'b1;
    st(3); `CHK("jog", 12'h12C, speedCmd)
    `CHK("jogt", 8'hC8, torqueCmd)
    w(8'h08, 16'h32); st(3); `CHK("jog", 12'h12C, speedCmd)
    @(posedge clk) inchingActive <= 1'b0;
    $display("t_ana done");
  endtask
  task t_misc;
    `CHK("wng", 1'b0, warningOutput)
    w(8'h07, 16'h1); st(3); `CHK("wng", 1'b1, warningOutput)
    w(8'h06, 16'h3C); @(posedge clk) loadPct <= 8'h3B;
    st(3); `CHK("wng", 1'b0, warningOutput)
    @(posedge clk) loadPct <= 8'h3C;
    st(3); `CHK("wng", 1'b1, warningOutput)
    `CHK("neg", 1'b1, dispNeg)
    w(8'h0A, 16'h1); st(3); `CHK("dsp", 13'h0064, dispSpeed)
    w(8'h13, 16'h8); st(3); `CHK("fwd", 1'b1, forwardRun)
    @(posedge clk) alarmOne <= 1'b1;
    st(2); `CHK("out", 16'h00C8, networkOutputBit)
    @(posedge clk) alarmActive <= 1'b1;
    st(2); `CHK("brk", 1'b1, brakeLock)
    w(8'h27, 16'h36); w(8'h29, 16'h15); w(8'h12, 16'h1); w(8'h13, 16'h0281);
    st(3); `CHK("tle", 1'b1, torqueLimitEnable)
    `CHK("dsel", 4'h1, dataSelectBit)
    `CHK("out", 16'h00C1, networkOutputBit)
    mdp_host_inst.rd(8'h29, rv); `CHK("sel", 16'h0, rv)
    @(posedge clk) auxPowerPin <= 1'b1;
    st(6); `CHK("heat", 1'b0, regenOverheat)
    w(8'h10, 16'h1); w(8'h12, 16'h1); @(posedge clk) auxPowerPin <= 1'b0;
    st(3); @(posedge clk) auxPowerPin <= 1'b1;
    st(6); `CHK("heat", 1'b1, regenOverheat)
    w(8'h0B, 16'h0); mdp_host_inst.wr(8'h04, 16'h10, 1'b1);
    mdp_host_inst.rd(8'h04, rv); `CHK("lock", 16'h03E8, rv)
    mdp_host_inst.rd(8'h40, rv); `CHK("unmap", 16'h0, rv)
    $display("t_misc done");
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    st(3);
    t_dflt();
    t_ana();
    t_misc();
    tally_and_finish();
  end
  initial begin
    #100000 error_cnt++;
    tally_and_finish();
  end
endmodule
